// [bsm_host_model.sv]
// host model: register requests and watchdog line on the system clock
// assumes the bench calls its tasks from code aligned to falling edges
`timescale 1ns/1ps
module bsm_host_model import bsm_pkg::*; (
   input wire logic clk,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid,
   output bsm_reg_req_t reg_req,
   output logic host_watchdog_reset_n
);
   // the undervoltage threshold is never programmed here
   initial begin
      reg_req = '0;
      host_watchdog_reset_n = 1'h1;
   end

   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_req = '{wr: w, rd: !w, addr: a, wdata: d};
      @(negedge clk);
      // idle bus shows the complement of the last address and data
      reg_req = '{wr: 1'h0, rd: 1'h0, addr: ~a, wdata: ~d};
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      xfer(1'h1, a, d);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      int n;
      n = 0;
      xfer(1'h0, a, 8'h00);
      while (reg_rvalid !== 1'h1 && n < 4) begin
         @(negedge clk);
         n++;
      end
      d = (reg_rvalid === 1'h1) ? reg_rdata : 8'hXX;
   endtask : rd

   // pulse shortened from the real hold time to suit the scaled tick
   task automatic wdog_low(input int n);
      @(negedge clk);
      host_watchdog_reset_n = 1'h0;
      repeat (n) @(negedge clk);
      host_watchdog_reset_n = 1'h1;
   endtask : wdog_low
endmodule : bsm_host_model

// [bsm_pkg.sv]
// constants, types and reset values of the buck system manager
// assumes one 125 MHz clock and a decoded serial-port register request
package bsm_pkg;
   localparam int CLK_MHZ = 125;
   localparam int BIAS_SETTLE_US = 50;
   localparam int BIAS_CYC = BIAS_SETTLE_US * CLK_MHZ;
   localparam int TICK_MS = 1;
   localparam int TICK_CYC = TICK_MS * 1000 * CLK_MHZ;
   localparam int DLY_STEP_MS = 2;
   localparam logic [5:0] SEQ_END_MS = 6'h3E;
   localparam int NUM_MASTERS = 4;

   localparam logic [7:0] ADDR_RESET = 8'h00;
   localparam logic [7:0] ADDR_INT_SRC = 8'h01;
   localparam logic [7:0] ADDR_INT_TOP = 8'h02;
   localparam logic [7:0] ADDR_INT_MASK = 8'h03;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_MASTER_EN = 8'h05;
   localparam logic [7:0] ADDR_GPI_CFG = 8'h06;
   localparam logic [7:0] ADDR_PHASE = 8'h07;
   localparam logic [7:0] ADDR_VOUT0 = 8'h10;
   localparam logic [7:0] ADDR_STUP0 = 8'h14;
   localparam logic [7:0] ADDR_SHDN0 = 8'h18;

   localparam int RST_SW_BIT = 0;
   localparam int RST_WDT_LSB = 4;
   localparam int GPI_GLB_BIT = 0;
   localparam int GPI_MAP_LSB = 4;

   localparam logic [3:0] EN_RST = 4'h0;
   localparam logic [3:0] MASK_RST = 4'hF;
   localparam logic [2:0] WATCHDOG_DEBOUNCE_SEL_RST = 3'h0;
   localparam logic [7:0] GPI_CFG_RST = 8'h00;
   localparam logic [7:0] VOUT_RST = 8'h78;
   localparam logic [19:0] STUP_RST = {5'h03, 5'h02, 5'h01, 5'h00};
   localparam logic [19:0] SHDN_RST = {5'h00, 5'h01, 5'h02, 5'h03};
   // watchdog debounce in ms, selected by a three-bit code
   localparam logic [63:0] WATCHDOG_DEBOUNCE_SEL_MS =
      {8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01};

   typedef enum logic [2:0] {
      PH_4 = 3'b000,
      PH_31 = 3'b001,
      PH_22 = 3'b010,
      PH_211 = 3'b011,
      PH_1111 = 3'b100
   } bsm_phase_t;

   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b00,
      SEQ_UP = 2'b01,
      SEQ_DOWN = 2'b10
   } bsm_seq_t;

   typedef struct packed {
      logic uvlo_ok;
      logic io_ok;
      logic tshdn_trip;
      logic tshdn_cool;
      logic twarn_lo;
      logic twarn_hi;
   } bsm_fault_t;

   typedef struct packed {
      logic chip_enable;
      logic en_pin;
      logic general_input_a;
      logic general_input_b;
      logic host_watchdog_reset_n;
      logic [2:0] phase_sel;
      bsm_fault_t fault;
   } bsm_pins_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } bsm_reg_req_t;
endpackage : bsm_pkg

// [bsm_top.sv]
// system manager of a multi-phase buck: faults, resets, enables, sequence,
// interrupts. assumes pins arrive asynchronously and register requests
// come as one-cycle strobes from the serial-port framer on clk.
`timescale 1ns/1ps

// How it works
// RULE_01 - phase select pins captured once after supply reset, then held
// RULE_02 - supply undervoltage forces shutdown until the supply indication recovers
// RULE_03 - host keeps programmed falling threshold below the rising one
// RULE_04 - io supply loss forces immediate shutdown until it returns
// RULE_05 - over-temperature soft-stops outputs, resets off-class, recovers on cool flag
// RULE_06 - two thermal warning inputs raise interrupt events
// RULE_07 - supply reset restores supply-class registers; shutdown until chip enable
// RULE_08 - every shutdown event resets off-class registers
// RULE_09 - soft reset bit resets off-class registers and self-clears
// RULE_10 - watchdog low beyond debounce resets output voltage settings
// RULE_11 - host drives watchdog input low about 100 ms on failure; the bench holds it low 40 cycles, 4 scaled ms
// RULE_12 - chip enable starts bias; masters held off until bias settles
// RULE_13 - chip enable low turns masters off and resets off-class registers
// RULE_14 - master on is OR of register, global and input enables
// RULE_15 - global enable edges start sequences with 32-step programmable delays
// RULE_16 - master one starts at once; shutdown delays from own registers
// RULE_17 - masters already held by own enables ignore the global sequence
// RULE_18 - interrupt pin low while unmasked bit set; source cleared on group read
// RULE_19 - interrupt bits set on condition rising edges only
// RULE_20 - bits clear on read; new event during read keeps pin low
// RULE_21 - mask blocks bit; unmasking active event captures it; masks default one
// RULE_22 - status bits show live conditions, never touch interrupt bits
// RULE_23 - interrupt pin not driven while chip enable is low
// RULE_24 - global enable is enable pin OR global function input
// RULE_25 - pins synchronised first; watchdog debounce restarts when input high
// RULE_26 - sequence delays count a millisecond tick, two ms per code
module bsm_top import bsm_pkg::*; #(
   parameter int BIAS_CYCLES = BIAS_CYC,
   parameter int TICK_CYCLES = TICK_CYC,
   parameter logic [7:0] VOUT_DEFAULT = VOUT_RST
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic chip_enable,
   input wire logic en_pin,
   input wire logic general_input_a,
   input wire logic general_input_b,
   input wire logic host_watchdog_reset_n,
   input wire logic phase_select_bit0,
   input wire logic phase_select_bit1,
   input wire logic phase_select_bit2,
   input wire bsm_fault_t fault_in,
   input wire bsm_reg_req_t reg_req,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   output logic [3:0] master_on,
   output bsm_phase_t phase_cfg,
   output logic [3:0] master_present,
   output logic [31:0] vout_setting,
   output logic soft_stop,
   output logic bias_ok,
   output logic shutdown,
   output logic irq_n_o,
   output logic irq_n_oe
);
   localparam int PW = $bits(bsm_pins_t);
   localparam int BW = $clog2(BIAS_CYCLES + 1);
   localparam int TW = $clog2(TICK_CYCLES + 1);

   logic [PW-1:0] meta_r, sync_r;
   bsm_pins_t pins;
   logic [1:0] ph_wait_r;
   logic ph_taken_r, hot_r, soft_reset_bit_r, bias_ok_r, shut_r, glb_d_r, tick;
   logic wdt_fired_r, wdt_fire_r, int_src_r, irq_oe_r, reg_rvalid_r;
   bsm_phase_t phase_r;
   bsm_seq_t seq_r;
   logic [3:0] present_r, en_r, mask_r, mask_d_r, cond_d_r, int_r;
   logic [3:0] glb_on_r, excl_r, master_on_r, own_en, m_in_en, cond;
   logic [3:0] int_set, int_nxt;
   logic [BW-1:0] bias_cnt_r;
   logic [TW-1:0] pre_r;
   logic [5:0] seq_ms_r;
   logic [7:0] wdt_ms_r, deb_ms, rd_mux, reg_rdata_r;
   logic [2:0] watchdog_debounce_sel_r;
   logic [7:0] gpi_cfg_r;
   logic [7:0] vout_r [NUM_MASTERS];
   logic [4:0] stup_r [NUM_MASTERS];
   logic [4:0] shdn_r [NUM_MASTERS];
   logic supplies_ok, shut_now, off_class, glb, glb_fn, seq_up, seq_down;
   logic int_rd;

   // two flops on every asynchronous pin; only sync_r is read
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         meta_r <= '0;
         sync_r <= '0;
      end else if (clk_en) begin
         meta_r <= {chip_enable, en_pin, general_input_a, general_input_b,
                    host_watchdog_reset_n, phase_select_bit2,
                    phase_select_bit1, phase_select_bit0, fault_in}; // RULE_25
         sync_r <= meta_r;
      end
   end
   assign pins = bsm_pins_t'(sync_r);

   // wait until the synchroniser holds real pin values before capturing
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ph_wait_r <= 2'h0;
         ph_taken_r <= 1'b0;
         phase_r <= PH_4;
         present_r <= 4'h1;
      end else if (clk_en && !ph_taken_r) begin
         if (ph_wait_r != 2'h2) begin
            ph_wait_r <= ph_wait_r + 2'h1;
         end else begin
            ph_taken_r <= 1'b1; // RULE_01
            phase_r <= pins.phase_sel[2] ? PH_1111 :
                       bsm_phase_t'(pins.phase_sel);
            case (pins.phase_sel[2] ? 3'b100 : pins.phase_sel)
               3'b000: present_r <= 4'h1;
               3'b001: present_r <= 4'h9;
               3'b010: present_r <= 4'h5;
               3'b011: present_r <= 4'hD;
               default: present_r <= 4'hF;
            endcase
         end
      end
   end

   assign supplies_ok = pins.fault.uvlo_ok & pins.fault.io_ok; // RULE_02 RULE_04
   assign shut_now = !pins.chip_enable | !supplies_ok | hot_r; // RULE_13
   assign off_class = shut_now | soft_reset_bit_r; // RULE_08 RULE_09

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         hot_r <= 1'b0;
         shut_r <= 1'b1;
      end else if (clk_en) begin
         shut_r <= shut_now;
         if (pins.fault.tshdn_trip) begin
            hot_r <= 1'b1; // RULE_05
         end else if (pins.fault.tshdn_cool) begin
            hot_r <= 1'b0;
         end
      end
   end

   // bias settles a fixed time after chip enable with good supplies
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         bias_cnt_r <= '0;
         bias_ok_r <= 1'b0;
      end else if (clk_en) begin
         if (!pins.chip_enable || !supplies_ok) begin
            bias_cnt_r <= '0;
            bias_ok_r <= 1'b0;
         end else if (bias_cnt_r == BW'(BIAS_CYCLES - 1)) begin
            bias_ok_r <= 1'b1; // RULE_12
         end else begin
            bias_cnt_r <= bias_cnt_r + BW'(1);
         end
      end
   end

   assign tick = (pre_r == TW'(TICK_CYCLES - 1));
   assign glb_fn = pins.general_input_a & gpi_cfg_r[GPI_GLB_BIT];
   assign glb = pins.en_pin | glb_fn; // RULE_24
   assign m_in_en = {4{pins.general_input_b}} & gpi_cfg_r[GPI_MAP_LSB +: 4];
   assign own_en = en_r | m_in_en;
   assign seq_up = glb & !glb_d_r;
   assign seq_down = !glb & glb_d_r;

   // prescaler restarts with each sequence so the first step is a full ms
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pre_r <= '0;
      end else if (clk_en) begin
         pre_r <= (tick || seq_up || seq_down) ? '0 : pre_r + TW'(1); // RULE_26
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         seq_r <= SEQ_IDLE;
         seq_ms_r <= 6'h00;
         glb_on_r <= 4'h0;
         excl_r <= 4'h0;
         glb_d_r <= 1'b0;
      end else if (clk_en) begin
         glb_d_r <= off_class ? 1'b0 : glb;
         if (off_class) begin
            seq_r <= SEQ_IDLE;
            seq_ms_r <= 6'h00;
            glb_on_r <= 4'h0;
            excl_r <= 4'h0;
         end else if (seq_up) begin
            seq_r <= SEQ_UP; // RULE_15
            seq_ms_r <= 6'h00;
            excl_r <= own_en; // RULE_17
            glb_on_r[0] <= glb_on_r[0] | !own_en[0]; // RULE_16
         end else if (seq_down) begin
            seq_r <= SEQ_DOWN;
            seq_ms_r <= 6'h00;
            excl_r <= own_en;
         end else if (seq_r != SEQ_IDLE) begin
            if (tick) begin
               seq_ms_r <= seq_ms_r + 6'h01;
            end
            if (seq_ms_r == SEQ_END_MS) begin
               seq_r <= SEQ_IDLE;
            end
            for (int m = 1; m < NUM_MASTERS; m++) begin
               if (seq_r == SEQ_UP && !excl_r[m] &&
                   seq_ms_r >= 6'(stup_r[m] * DLY_STEP_MS)) begin
                  glb_on_r[m] <= 1'b1; // RULE_16
               end
            end
            for (int m = 0; m < NUM_MASTERS; m++) begin
               if (seq_r == SEQ_DOWN && !excl_r[m] &&
                   seq_ms_r >= 6'(shdn_r[m] * DLY_STEP_MS)) begin
                  glb_on_r[m] <= 1'b0; // RULE_16
               end
            end
         end
      end
   end

   // enabling before bias is ready only postpones the start
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         master_on_r <= 4'h0;
      end else if (clk_en) begin
         master_on_r <= off_class ? 4'h0 :
            present_r & {4{bias_ok_r}} & (own_en | glb_on_r); // RULE_14
      end
   end

   // debounce restarts whenever the watchdog input goes back high
   assign deb_ms = WATCHDOG_DEBOUNCE_SEL_MS[{watchdog_debounce_sel_r, 3'b000} +: 8];
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wdt_ms_r <= 8'h00;
         wdt_fired_r <= 1'b0;
         wdt_fire_r <= 1'b0;
      end else if (clk_en) begin
         wdt_fire_r <= 1'b0;
         if (pins.host_watchdog_reset_n) begin
            wdt_ms_r <= 8'h00; // RULE_25
            wdt_fired_r <= 1'b0;
         end else if (tick && !wdt_fired_r) begin
            if (wdt_ms_r == deb_ms) begin
               wdt_fired_r <= 1'b1;
               wdt_fire_r <= 1'b1; // RULE_10
            end else begin
               wdt_ms_r <= wdt_ms_r + 8'h01;
            end
         end
      end
   end

   for (genvar g = 0; g < NUM_MASTERS; g++) begin : g_master
      always_ff @(posedge clk) begin
         if (sys_rst) begin
            vout_r[g] <= VOUT_DEFAULT; // RULE_07
            stup_r[g] <= STUP_RST[5*g +: 5];
            shdn_r[g] <= SHDN_RST[5*g +: 5];
         end else if (clk_en) begin
            if (off_class) begin
               vout_r[g] <= VOUT_DEFAULT; // RULE_08
               stup_r[g] <= STUP_RST[5*g +: 5];
               shdn_r[g] <= SHDN_RST[5*g +: 5];
            end else begin
               if (wdt_fire_r) begin
                  vout_r[g] <= VOUT_DEFAULT; // RULE_10
               end else if (reg_req.wr && reg_req.addr == ADDR_VOUT0 + 8'(g)) begin
                  vout_r[g] <= reg_req.wdata;
               end
               if (reg_req.wr && reg_req.addr == ADDR_STUP0 + 8'(g)) begin
                  stup_r[g] <= reg_req.wdata[4:0];
               end
               if (reg_req.wr && reg_req.addr == ADDR_SHDN0 + 8'(g)) begin
                  shdn_r[g] <= reg_req.wdata[4:0];
               end
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         en_r <= EN_RST;
         mask_r <= MASK_RST;
         soft_reset_bit_r <= 1'b0;
         watchdog_debounce_sel_r <= WATCHDOG_DEBOUNCE_SEL_RST;
         gpi_cfg_r <= GPI_CFG_RST;
      end else if (clk_en) begin
         soft_reset_bit_r <= !soft_reset_bit_r && reg_req.wr && reg_req.addr == ADDR_RESET &&
                     reg_req.wdata[RST_SW_BIT]; // RULE_09
         if (reg_req.wr && reg_req.addr == ADDR_RESET) begin
            watchdog_debounce_sel_r <= reg_req.wdata[RST_WDT_LSB +: 3];
         end
         if (reg_req.wr && reg_req.addr == ADDR_GPI_CFG) begin
            gpi_cfg_r <= reg_req.wdata;
         end
         if (off_class) begin
            en_r <= EN_RST;
            mask_r <= MASK_RST; // RULE_21
         end else begin
            if (reg_req.wr && reg_req.addr == ADDR_MASTER_EN) begin
               en_r <= reg_req.wdata[3:0];
            end
            if (reg_req.wr && reg_req.addr == ADDR_INT_MASK) begin
               mask_r <= reg_req.wdata[3:0];
            end
         end
      end
   end

   // set beats a same-cycle clear-on-read so no event is lost
   assign cond = {bias_ok_r, hot_r, pins.fault.twarn_hi, pins.fault.twarn_lo}; // RULE_06
   assign int_set = ((cond & ~cond_d_r) | (mask_d_r & ~mask_r & cond))
                    & ~mask_r; // RULE_19 RULE_21
   assign int_rd = reg_req.rd && reg_req.addr == ADDR_INT_TOP;
   assign int_nxt = (int_r & ~{4{int_rd}}) | int_set; // RULE_20

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cond_d_r <= 4'h0;
         mask_d_r <= MASK_RST;
         int_r <= 4'h0;
         int_src_r <= 1'b0;
         irq_oe_r <= 1'b0;
      end else if (clk_en) begin
         cond_d_r <= cond;
         mask_d_r <= mask_r;
         int_r <= int_nxt;
         int_src_r <= (|int_set) | (int_src_r & !int_rd); // RULE_18
         irq_oe_r <= pins.chip_enable & (|(int_nxt & ~mask_r)); // RULE_23
      end
   end

   always_comb begin
      rd_mux = 8'h00;
      case (reg_req.addr)
         ADDR_RESET: rd_mux = {1'b0, watchdog_debounce_sel_r, 3'b000, soft_reset_bit_r};
         ADDR_INT_SRC: rd_mux = {7'h00, int_src_r};
         ADDR_INT_TOP: rd_mux = {4'h0, int_r};
         ADDR_INT_MASK: rd_mux = {4'h0, mask_r};
         ADDR_STATUS: rd_mux = {2'b00, pins.fault.uvlo_ok, pins.fault.io_ok,
                                bias_ok_r, hot_r, pins.fault.twarn_hi,
                                pins.fault.twarn_lo}; // RULE_22
         ADDR_MASTER_EN: rd_mux = {4'h0, en_r};
         ADDR_GPI_CFG: rd_mux = gpi_cfg_r;
         ADDR_PHASE: rd_mux = {5'h00, phase_r};
         default: begin
            if (reg_req.addr[7:2] == ADDR_VOUT0[7:2]) begin
               rd_mux = vout_r[reg_req.addr[1:0]];
            end else if (reg_req.addr[7:2] == ADDR_STUP0[7:2]) begin
               rd_mux = {3'b000, stup_r[reg_req.addr[1:0]]};
            end else if (reg_req.addr[7:2] == ADDR_SHDN0[7:2]) begin
               rd_mux = {3'b000, shdn_r[reg_req.addr[1:0]]};
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         reg_rdata_r <= 8'h00;
         reg_rvalid_r <= 1'b0;
      end else if (clk_en) begin
         reg_rvalid_r <= reg_req.rd;
         if (reg_req.rd) begin
            reg_rdata_r <= rd_mux;
         end
      end
   end

   assign reg_rdata = reg_rdata_r;
   assign reg_rvalid = reg_rvalid_r;
   assign master_on = master_on_r;
   assign phase_cfg = phase_r;
   assign master_present = present_r;
   assign vout_setting = {vout_r[3], vout_r[2], vout_r[1], vout_r[0]};
   assign soft_stop = hot_r;
   assign bias_ok = bias_ok_r;
   assign shutdown = shut_r;
   assign irq_n_o = 1'b0;
   assign irq_n_oe = irq_oe_r;

   sequence sw_write_s;
      clk_en && !soft_reset_bit_r && reg_req.wr && reg_req.addr == ADDR_RESET &&
      reg_req.wdata[RST_SW_BIT];
   endsequence
   sequence glb_rise_s;
      clk_en && !off_class && seq_up && !own_en[0];
   endsequence

   phase_hold_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_01
      ph_taken_r |=> $stable(phase_r)) else $error("phase config changed");
   uvlo_off_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_02
      clk_en && !pins.fault.uvlo_ok |=> master_on_r == 4'h0)
      else $error("master on under undervoltage");
   vio_off_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_04
      clk_en && !pins.fault.io_ok |=> master_on_r == 4'h0)
      else $error("master on without io supply");
   ce_off_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_13
      clk_en && !pins.chip_enable |=> master_on_r == 4'h0 && en_r == EN_RST)
      else $error("chip enable low did not shut down");
   sw_reset_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_09
      sw_write_s |=> (soft_reset_bit_r and
         (clk_en |=> !soft_reset_bit_r && mask_r == MASK_RST)))
      else $error("soft reset did not reset and clear");
   wdt_vout_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_10
      clk_en && wdt_fire_r |=> vout_r[0] == VOUT_DEFAULT)
      else $error("watchdog did not restore voltage");
   or_enable_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_14
      clk_en && !off_class && bias_ok_r && present_r[0] &&
      (en_r[0] || glb_on_r[0]) |=> master_on_r[0])
      else $error("enabled master is off");
   master_first_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_16
      glb_rise_s |=> glb_on_r[0]) else $error("master one not started");
   read_clear_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_20
      clk_en && int_rd && cond[0] && cond_d_r[0] && mask_r == mask_d_r
      |=> !int_r[0]) else $error("persisting event set bit again");
   irq_low_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_18
      clk_en && pins.chip_enable && !int_rd && |(int_r & ~mask_r)
      |=> irq_n_oe) else $error("interrupt pin not asserted");
   irq_hiz_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_23
      clk_en && !pins.chip_enable |=> !irq_n_oe)
      else $error("interrupt pin driven with chip disabled");
   mask_block_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_21
      clk_en && mask_r == 4'hF && int_r == 4'h0 |=> int_r == 4'h0)
      else $error("masked event set a bit");
endmodule : bsm_top

// [test_buck_system_manager.sv]
// bench for the buck system manager: faults, resets, sequence, interrupts
// assumes the host model drives the register port and the watchdog line
`timescale 1ns/1ps
module test_buck_system_manager import bsm_pkg::*;;
   logic clk = 1'h0, sys_rst = 1'h1, ce = 1'h0, en_pin = 1'h0;
   logic gia = 1'h0, gib = 1'h0, rvalid, sstop, bok, sd, irq_o, irq_oe, wdn;
   logic [2:0] ph = 3'h2;
   bsm_fault_t flt = 6'h30;
   bsm_reg_req_t req;
   bsm_phase_t phc;
   logic [7:0] rdata;
   logic [3:0] mon, pres;
   logic [31:0] vout;
   int err_count = 0, n_compared = 0;

   always #4 clk = ~clk;

   bsm_top #(.BIAS_CYCLES(8), .TICK_CYCLES(10)) bsm_top_inst (.clk(clk),
      .sys_rst(sys_rst), .clk_en(1'h1), .chip_enable(ce), .en_pin(en_pin),
      .general_input_a(gia), .general_input_b(gib),
      .host_watchdog_reset_n(wdn), .phase_select_bit0(ph[0]),
      .phase_select_bit1(ph[1]), .phase_select_bit2(ph[2]), .fault_in(flt),
      .reg_req(req), .reg_rdata(rdata), .reg_rvalid(rvalid),
      .master_on(mon), .phase_cfg(phc), .master_present(pres),
      .vout_setting(vout), .soft_stop(sstop), .bias_ok(bok),
      .shutdown(sd), .irq_n_o(irq_o), .irq_n_oe(irq_oe));
   bsm_host_model bsm_host_model_inst (.clk(clk), .reg_rdata(rdata),
      .reg_rvalid(rvalid), .reg_req(req), .host_watchdog_reset_n(wdn));

   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e) begin
         err_count++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : cyc
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bsm_host_model_inst.wr(a, d);
   endtask : wr
   task automatic rdchk(input string nm, input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      bsm_host_model_inst.rd(a, d);
      chk(nm, d, e);
   endtask : rdchk
   task automatic wait_bias;
      int n;
      n = 0;
      while (bok !== 1'h1 && n < 40) begin
         cyc(1);
         n++;
      end
      chk("bias_ok", bok, 1'h1);
      chk("shutdown", sd, 1'h0);
   endtask : wait_bias

   task automatic t_phase_bias;
      chk("phase", phc, PH_22);
      chk("present", pres, 4'h5);
      ph = 3'h4;
      ce = 1'h1;
      cyc(4);
      chk("bias early", bok, 1'h0);
      chk("phase held", phc, PH_22);
      wait_bias();
   endtask : t_phase_bias

   task automatic t_enables;
      wr(8'h05, 8'h01);
      cyc(3);
      chk("reg enable", mon, 4'h1);
      wr(8'h05, 8'h00);
      wr(8'h06, 8'h40);
      gib = 1'h1;
      cyc(6);
      chk("input enable", mon, 4'h4);
      gib = 1'h0;
      wr(8'h06, 8'h01);
      gia = 1'h1;
      cyc(30);
      chk("seq up m1", mon, 4'h1);
      cyc(30);
      chk("seq up m3", mon, 4'h5);
      gia = 1'h0;
      cyc(12);
      chk("seq dn hold", mon, 4'h5);
      cyc(28);
      chk("seq dn m3", mon, 4'h1);
      cyc(50);
      chk("seq dn m1", mon, 4'h0);
      wr(8'h05, 8'h04);
      en_pin = 1'h1;
      cyc(60);
      // master index 2 was own-enabled at the start, so the global
      // sequence never took it over: dropping its bit turns it off
      wr(8'h05, 8'h00);
      cyc(3);
      chk("own enable kept", mon, 4'h1);
      en_pin = 1'h0;
      cyc(90);
      chk("excluded down", mon, 4'h0);
   endtask : t_enables

   task automatic t_faults;
      for (int i = 0; i < 2; i++) begin
         wr(8'h05, 8'h01);
         flt[4+i] = 1'h0;
         cyc(6);
         chk("fault shutdown", sd, 1'h1);
         chk("fault off", mon, 4'h0);
         flt[4+i] = 1'h1;
         wait_bias();
         rdchk("off reset", 8'h05, 8'h00);
      end
      wr(8'h05, 8'h01);
      flt.tshdn_trip = 1'h1;
      cyc(6);
      chk("hot stop", sstop, 1'h1);
      chk("hot off", mon, 4'h0);
      rdchk("hot port", 8'h05, 8'h00);
      flt.tshdn_trip = 1'h0;
      flt.tshdn_cool = 1'h1;
      cyc(6);
      chk("cooled", sstop, 1'h0);
      flt.tshdn_cool = 1'h0;
      wait_bias();
   endtask : t_faults

   task automatic t_resets;
      wr(8'h05, 8'h01);
      wr(8'h00, 8'h01);
      cyc(3);
      chk("soft off", mon, 4'h0);
      rdchk("soft bit", 8'h00, 8'h00);
      wr(8'h10, 8'h20);
      rdchk("vout wr", 8'h10, 8'h20);
      bsm_host_model_inst.wdog_low(40);
      cyc(5);
      rdchk("vout dflt", 8'h10, 8'h78);
      chk("vout out", vout[7:0], 8'h78);
   endtask : t_resets

   task automatic t_irq;
      wr(8'h03, 8'h0C);
      flt.twarn_lo = 1'h1;
      flt.twarn_hi = 1'h1;
      cyc(6);
      chk("irq set", irq_oe, 1'h1);
      rdchk("int src", 8'h01, 8'h01);
      rdchk("int bits", 8'h02, 8'h03);
      cyc(2);
      chk("irq free", irq_oe, 1'h0);
      rdchk("src clr", 8'h01, 8'h00);
      rdchk("no reset", 8'h02, 8'h00);
      rdchk("status", 8'h04, 8'h3B);
      wr(8'h03, 8'h0F);
      wr(8'h03, 8'h0C);
      cyc(3);
      chk("unmask capt", irq_oe, 1'h1);
      ce = 1'h0;
      cyc(6);
      chk("irq hiz", irq_oe, 1'h0);
      chk("irq data", irq_o, 1'h0);
      chk("ce shutdown", sd, 1'h1);
      ce = 1'h1;
      wait_bias();
      rdchk("mask dflt", 8'h03, 8'h0F);
   endtask : t_irq

   task automatic end_sim;
      $display("mismatches %0d compared %0d", err_count, n_compared);
      if (err_count == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : end_sim

   initial begin
      repeat (3) @(posedge clk);
      @(negedge clk);
      sys_rst = 1'h0;
      cyc(6);
      t_phase_bias();
      t_enables();
      t_faults();
      t_resets();
      t_irq();
      end_sim();
   end

   // whole run is near five hundred cycles
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      end_sim();
   end
endmodule : test_buck_system_manager
